// [rtl/bcd_millisecond_stopwatch.sv]
`timescale 1ns/1ns
`default_nettype none
`include "stopwatch_map.svh"

module bcd_millisecond_stopwatch
  import stopwatch_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `MS_PERIOD_NS / `CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Register port
  input wire reg_req_t reg_req_in,
  output logic [`DATA_W-1:0] rd_data_out,
  // Trigger pin and prescaler taps
  input wire logic trigger_input_pin_in,
  input wire logic prescaler_tap_fast_in,
  input wire logic prescaler_tap_slow_in,
  // Status
  output logic counter_irq_request_out,
  output logic counting_out
);

  localparam logic [`MS_CNT_W-1:0] MS_LAST = `MS_CNT_W'(MS_CYCLES - 1);

  sw_state_t st_reg;
  sw_state_t st_next;

  logic ctl_wr;
  logic cfg_wr;
  logic cfg_rd;
  logic do_clear;
  logic ms_tick;
  logic tap_tick;
  logic cond;
  logic cond_rise;
  logic cond_fall;
  logic [`DIGITS:0] carry;
  logic [`DIGITS-1:0][`DATA_W-1:0] digits_adv;

  // Register port decode
  assign ctl_wr = reg_req_in.wr && (reg_req_in.addr == `ADDR_CTL);
  assign cfg_wr = reg_req_in.wr && (reg_req_in.addr == `ADDR_CFG);
  assign cfg_rd = reg_req_in.rd && (reg_req_in.addr == `ADDR_CFG);
  assign do_clear = ctl_wr && reg_req_in.wdata[`CTL_CLEAR_BIT];

  // Millisecond step from the free-running divider
  assign ms_tick = (st_reg.ms_cnt == MS_LAST);

  // Selected debounce tap, taken on its rising edge
  assign tap_tick = st_reg.debounce_rate_select ?
                    (prescaler_tap_slow_in && !st_reg.tap_slow_prev) :
                    (prescaler_tap_fast_in && !st_reg.tap_fast_prev);

  // Private polarity; no port-wide edge or pull setting enters here
  assign cond = st_reg.trigger_edge_select ? st_reg.deb : !st_reg.deb;
  assign cond_rise = cond && !st_reg.cond_prev;
  assign cond_fall = !cond && st_reg.cond_prev;

  // Decimal carry chain, one stage per digit
  assign carry[0] = ms_tick && st_reg.counting;
  genvar gi;
  generate
    for (gi = 0; gi < `DIGITS; gi++) begin : g_digit
      assign carry[gi+1] = carry[gi] && (st_reg.digits[gi] == `BCD_NINE);
      assign digits_adv[gi] = !carry[gi] ? st_reg.digits[gi] :
                              (st_reg.digits[gi] == `BCD_NINE) ? `DATA_W'(0) :
                              st_reg.digits[gi] + `DATA_W'(1);
    end
  endgenerate

  // Next-state logic
  always_comb begin
    st_next = st_reg;
    // Two-flop synchroniser on the pin
    st_next.pin_meta = trigger_input_pin_in;
    st_next.pin_sync = st_reg.pin_meta;
    st_next.tap_fast_prev = prescaler_tap_fast_in;
    st_next.tap_slow_prev = prescaler_tap_slow_in;
    // Level accepted only after two equal samples on the tap
    if (tap_tick) begin
      st_next.pin_samp = st_reg.pin_sync;
      if (st_reg.pin_sync == st_reg.pin_samp) begin
        st_next.deb = st_reg.pin_samp;
      end
    end
    st_next.cond_prev = cond;
    st_next.ms_cnt = ms_tick ? '0 : st_reg.ms_cnt + `MS_CNT_W'(1);

    // Pin events; only looked at under pin control
    unique case (st_reg.state)
      ST_STOP: begin
        if (st_reg.pin_or_cpu_control && st_reg.run_enable && cond_rise) begin
          st_next.state = ST_PIN_RUN;
        end
      end
      ST_CPU_RUN: begin
        if (st_reg.pin_or_cpu_control && cond_rise) begin
          st_next.state = ST_STOP;
          if (st_reg.pulse_width_select) begin
            st_next.run_enable = 1'b0;
          end
        end
      end
      ST_PIN_RUN: begin
        if (st_reg.pulse_width_select ? cond_fall : cond_rise) begin
          st_next.state = ST_STOP;
          if (st_reg.pulse_width_select) begin
            st_next.run_enable = 1'b0;
          end
        end
      end
    endcase

    // Software write wins over the automatic clear of run enable
    if (ctl_wr) begin
      st_next.run_enable = reg_req_in.wdata[`CTL_RUN_BIT];
      st_next.pin_or_cpu_control = reg_req_in.wdata[`CTL_PIN_BIT];
      st_next.pulse_width_select = reg_req_in.wdata[`CTL_PULSE_BIT];
    end
    if (cfg_wr) begin
      st_next.debounce_rate_select = reg_req_in.wdata[`CFG_DEB_BIT];
      st_next.trigger_edge_select = reg_req_in.wdata[`CFG_EDGE_BIT];
      st_next.irq_rate_select = reg_req_in.wdata[`CFG_IRQ_BIT];
    end

    // CPU control follows run enable directly; pin edges are ignored
    if (!st_next.pin_or_cpu_control) begin
      st_next.state = st_next.run_enable ? ST_CPU_RUN : ST_STOP;
    end else if (!st_next.run_enable) begin
      st_next.state = ST_STOP;
    end
    st_next.counting = (st_next.state != ST_STOP);

    // Count update; clear beats the step
    st_next.digits = do_clear ? '0 : digits_adv;

    // Periodic request as a one-cycle pulse
    st_next.irq = st_reg.irq_rate_select ? carry[`DIGITS] :
                  carry[`TENTHS_CARRY];

    // Seconds flag: reaching 999 wins over the read clear
    if (carry[0] && !do_clear && (digits_adv == `BCD_MAX)) begin
      st_next.seconds_rollover_flag = 1'b1;
    end else if (cfg_rd) begin
      st_next.seconds_rollover_flag = 1'b0;
    end

    // Read data stand only in the cycle after the strobe
    st_next.rd_data = '0;
    if (reg_req_in.rd) begin
      unique case (reg_req_in.addr)
        `ADDR_CTL: begin
          st_next.rd_data = {st_reg.run_enable, st_reg.pin_or_cpu_control,
                             st_reg.pulse_width_select, 1'b0};
        end
        `ADDR_CFG: begin
          st_next.rd_data = {st_reg.debounce_rate_select, st_reg.trigger_edge_select,
                             st_reg.irq_rate_select, st_reg.seconds_rollover_flag};
        end
        `ADDR_THOUSANDTHS: st_next.rd_data = st_reg.digits[0];
        `ADDR_HUNDREDTHS: st_next.rd_data = st_reg.digits[1];
        `ADDR_TENTHS: st_next.rd_data = st_reg.digits[2];
        default: st_next.rd_data = '0;
      endcase
    end
  end

  // State register; reset stops and clears everything
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data_out = st_reg.rd_data;
  assign counter_irq_request_out = st_reg.irq;
  assign counting_out = st_reg.counting;

  // Checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_pin_armed_rise;
    st_reg.pin_or_cpu_control && st_reg.run_enable && st_reg.state == ST_STOP &&
    cond_rise && !reg_req_in.wr;
  endsequence

  sequence s_pw_fall;
    st_reg.state == ST_PIN_RUN && st_reg.pin_or_cpu_control &&
    st_reg.pulse_width_select && cond_fall && !reg_req_in.wr;
  endsequence

  chk_clear_zeroes: assert property (do_clear |=> st_reg.digits == '0)
    else $error("count not zero after clear");

  chk_clear_reads_zero: assert property (
    reg_req_in.rd && reg_req_in.addr == `ADDR_CTL |=> !rd_data_out[`CTL_CLEAR_BIT])
    else $error("clear bit read back as one");

  chk_cpu_start: assert property (
    ctl_wr && reg_req_in.wdata[`CTL_RUN_BIT] && !reg_req_in.wdata[`CTL_PIN_BIT]
    |=> counting_out ##0 st_reg.state == ST_CPU_RUN)
    else $error("cpu start did not start counting");

  chk_cpu_stop: assert property (
    ctl_wr && !reg_req_in.wdata[`CTL_RUN_BIT] |=> !counting_out)
    else $error("run enable cleared but still counting");

  chk_pin_start: assert property (s_pin_armed_rise |=> counting_out)
    else $error("armed counter missed active edge");

  chk_pw_stop_clear: assert property (s_pw_fall |=> !counting_out && !st_reg.run_enable)
    else $error("pulse mode did not stop and disarm");

  chk_wrap_zero: assert property (
    st_reg.digits == `BCD_MAX && carry[0] && !do_clear |=> st_reg.digits == '0)
    else $error("count did not wrap to zero");

  chk_irq_tenth: assert property (
    !st_reg.irq_rate_select && carry[`TENTHS_CARRY] |=> counter_irq_request_out)
    else $error("tenth second request missing");

  chk_irq_second: assert property (
    counter_irq_request_out && $past(st_reg.irq_rate_select)
    |-> st_reg.digits == '0 || $past(do_clear))
    else $error("second request without wrap");

  chk_sec_flag_set: assert property (
    $changed(st_reg.digits) && st_reg.digits == `BCD_MAX |-> st_reg.seconds_rollover_flag)
    else $error("seconds flag not set at 999");

  chk_deb_on_tap: assert property ($changed(st_reg.deb) |-> $past(tap_tick))
    else $error("debounced level moved off tap");

  chk_cpu_ignores_pin: assert property (
    !st_reg.pin_or_cpu_control && !reg_req_in.wr && st_reg.run_enable
    |=> counting_out)
    else $error("pin edge affected cpu control");

  // Pin event steps used by the mode checks below
  sequence s_cpu_run_rise;
    st_reg.state == ST_CPU_RUN && st_reg.pin_or_cpu_control &&
    cond_rise && !reg_req_in.wr;
  endsequence

  sequence s_ss_rise;
    st_reg.state == ST_PIN_RUN && st_reg.pin_or_cpu_control &&
    !st_reg.pulse_width_select && cond_rise && !reg_req_in.wr;
  endsequence

  sequence s_armed_quiet;
    st_reg.state == ST_STOP && st_reg.pin_or_cpu_control &&
    !cond_rise && !reg_req_in.wr;
  endsequence

  // Reset must win on its own edge, so this one is not disabled by it
  chk_reset_stops: assert property (@(posedge core_clk_in) disable iff (1'b0)
    sys_rst_in |=> !counting_out && st_reg.digits == '0 && !st_reg.run_enable)
    else $error("reset left the counter running");

  // Read data is zero outside the cycle after a read strobe
  chk_rd_idle_zero: assert property (!reg_req_in.rd |=> rd_data_out == '0)
    else $error("read data outside its cycle");

  // Every digit stays a legal decimal digit
  chk_digit_range: assert property (
    st_reg.digits[0] <= `BCD_NINE && st_reg.digits[1] <= `BCD_NINE &&
    st_reg.digits[2] <= `BCD_NINE)
    else $error("digit out of decimal range");

  // One step adds exactly one to the lowest digit
  chk_step_one: assert property (
    carry[0] && !do_clear && st_reg.digits[0] != `BCD_NINE
    |=> st_reg.digits[0] == $past(st_reg.digits[0]) + 4'h1)
    else $error("count step not by one");

  // A stopped counter holds its value
  chk_hold_stopped: assert property (
    !st_reg.counting && !do_clear |=> $stable(st_reg.digits))
    else $error("count moved while stopped");

  // Start/stop mode: a rise stops, run enable survives
  chk_ss_keep_run: assert property (
    s_ss_rise |=> !counting_out && st_reg.run_enable)
    else $error("start/stop mode lost run enable");

  // CPU-started count stopped by the pin; run cleared only in pulse mode
  chk_cpu_pin_stop: assert property (
    s_cpu_run_rise |=> !counting_out &&
    (st_reg.run_enable == !$past(st_reg.pulse_width_select)))
    else $error("pin stop of cpu count wrong");

  // Armed but no active edge: nothing counts
  chk_armed_no_count: assert property (s_armed_quiet |=> !counting_out)
    else $error("armed counter started without edge");

  // Pulse mode keeps running until the falling edge
  chk_pulse_hold: assert property (
    st_reg.state == ST_PIN_RUN && st_reg.pin_or_cpu_control && st_reg.run_enable &&
    st_reg.pulse_width_select && !cond_fall && !reg_req_in.wr |=> counting_out)
    else $error("pulse mode stopped early");

  // Reading the config register clears the flag when nothing sets it
  chk_flag_read_clear: assert property (cfg_rd && !carry[0] |=> !st_reg.seconds_rollover_flag)
    else $error("seconds flag survived a read");

  // The request is a single-cycle pulse
  chk_irq_one_cycle: assert property (
    counter_irq_request_out |=> !counter_irq_request_out)
    else $error("request longer than one cycle");

  // Software write of run enable beats the automatic clear
  chk_ctl_write_wins: assert property (
    ctl_wr |=> st_reg.run_enable == $past(reg_req_in.wdata[`CTL_RUN_BIT]))
    else $error("run enable write lost");

  // Config write lands in the edge and interrupt rate bits
  chk_cfg_write: assert property (
    cfg_wr |=> st_reg.trigger_edge_select == $past(reg_req_in.wdata[`CFG_EDGE_BIT]) &&
    st_reg.irq_rate_select == $past(reg_req_in.wdata[`CFG_IRQ_BIT]))
    else $error("config write lost");

endmodule
`default_nettype wire

// [rtl/stopwatch_map.svh]
`ifndef STOPWATCH_MAP_SVH
`define STOPWATCH_MAP_SVH

// Timing: core clock period and one count step, both in ns
`define CLK_PERIOD_NS 100
`define MS_PERIOD_NS 1000000
`define MS_CNT_W 16

// Register indices on the plain register port
`define ADDR_W 3
`define ADDR_CTL 3'h0
`define ADDR_CFG 3'h1
`define ADDR_THOUSANDTHS 3'h2
`define ADDR_HUNDREDTHS 3'h3
`define ADDR_TENTHS 3'h4

// Control register fields
`define CTL_RUN_BIT 3
`define CTL_PIN_BIT 2
`define CTL_PULSE_BIT 1
`define CTL_CLEAR_BIT 0

// Config and flags register fields
`define CFG_DEB_BIT 3
`define CFG_EDGE_BIT 2
`define CFG_IRQ_BIT 1
`define CFG_SEC_BIT 0

// Decimal count layout and limits
`define DATA_W 4
`define DIGITS 3
`define BCD_NINE 4'h9
`define BCD_MAX 12'h999
`define TENTHS_CARRY 2

`endif

// [rtl/stopwatch_pkg.sv]
`include "stopwatch_map.svh"

package stopwatch_pkg;

  // Register port request, one cycle per access
  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef enum logic [1:0] {ST_STOP, ST_CPU_RUN, ST_PIN_RUN} run_state_t;

  // Whole state of the stopwatch
  typedef struct packed {
    run_state_t state;
    logic counting;
    logic run_enable;
    logic pin_or_cpu_control;
    logic pulse_width_select;
    logic debounce_rate_select;
    logic trigger_edge_select;
    logic irq_rate_select;
    logic seconds_rollover_flag;
    logic [`DIGITS-1:0][`DATA_W-1:0] digits;
    logic [`MS_CNT_W-1:0] ms_cnt;
    logic pin_meta;
    logic pin_sync;
    logic pin_samp;
    logic deb;
    logic cond_prev;
    logic tap_fast_prev;
    logic tap_slow_prev;
    logic [`DATA_W-1:0] rd_data;
    logic irq;
  } sw_state_t;

endpackage

// [tb/trigger_pin_model.sv]
`timescale 1ns/1ns
`default_nettype none
module trigger_pin_model (
  // Clock and requested pin level
  input wire logic core_clk_in,
  input wire logic level_in,
  // Pin and prescaler taps
  output logic trigger_input_pin_out,
  output logic prescaler_tap_fast_out,
  output logic prescaler_tap_slow_out
);
  logic [4:0] div_reg = 5'h00;
  logic last1_reg = 1'b0;
  logic last2_reg = 1'b0;
  logic pin_reg = 1'b0;
  // Contact bounce: one cycle back at the old level after each change
  always @(posedge core_clk_in) begin
    div_reg <= div_reg + 5'h01;
    last1_reg <= level_in;
    last2_reg <= last1_reg;
    pin_reg <= (last1_reg != last2_reg) ? last2_reg : level_in;
  end
  assign trigger_input_pin_out = pin_reg;
  // Fast tap is eight times the slow one
  assign prescaler_tap_fast_out = div_reg[1];
  assign prescaler_tap_slow_out = div_reg[4];
endmodule
`default_nettype wire

// [tb/tb_bcd_millisecond_stopwatch.sv]
`timescale 1ns/1ns
`default_nettype none
`include "stopwatch_map.svh"
module tb_bcd_millisecond_stopwatch;
  import stopwatch_pkg::*;
  logic core_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  reg_req_t req = '0;
  logic pin_level = 1'b0;
  logic [`DATA_W-1:0] rd_data;
  logic pin, tap_f, tap_s, irq, counting;
  logic rd_d = 1'b0;
  logic [`DATA_W-1:0] exp_q[$];
  int bad_count = 0;
  int n_compared = 0;
  int irq_n = 0;
  int cyc = 0;
  logic [31:0] t;

  always #50 core_clk_in = ~core_clk_in;

  trigger_pin_model u_pin (.core_clk_in(core_clk_in), .level_in(pin_level),
    .trigger_input_pin_out(pin), .prescaler_tap_fast_out(tap_f),
    .prescaler_tap_slow_out(tap_s));
  // Short millisecond so a full wrap fits the run
  bcd_millisecond_stopwatch #(.MS_CYCLES(10)) u_dut (.core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in), .reg_req_in(req), .rd_data_out(rd_data),
    .trigger_input_pin_in(pin), .prescaler_tap_fast_in(tap_f),
    .prescaler_tap_slow_in(tap_s), .counter_irq_request_out(irq),
    .counting_out(counting));

  task automatic test_done;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [`ADDR_W-1:0] a, input logic [3:0] d);
    @(posedge core_clk_in);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_in);
    req <= '0;
  endtask

  // Read with its expected value noted for the monitor
  task automatic rd(input logic [`ADDR_W-1:0] a, input logic [3:0] e);
    exp_q.push_back(e);
    @(posedge core_clk_in);
    req <= '{addr: a, wdata: 4'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_in);
    req <= '0;
  endtask

  // Bounded wait for the run level, with a lower bound on the latency
  task automatic wait_cnt(input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while (counting !== v && n < hi) begin
      @(posedge core_clk_in);
      #1;
      n++;
    end
    check("counting", counting, v);
    check("latency_ok", n >= lo, 1'b1);
  endtask

  // Read data stands only in the cycle after the strobe; interrupts and timeout
  always @(posedge core_clk_in) begin
    rd_d <= req.rd;
    cyc++;
    if (irq === 1'b1) irq_n++;
    if (cyc == 20000) begin
      bad_count++;
      test_done();
    end
  end
  always @(negedge core_clk_in) begin
    if (rd_d === 1'b1) check("rd_data", {8'h00, rd_data}, {8'h00, exp_q.pop_front()});
  end

  initial begin
    void'($urandom(88));
    repeat (12) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    for (int a = 0; a < 6; a++) rd(a, 4'h0);
    t = $urandom;
    wr(`ADDR_CFG, t[3:0]);
    rd(`ADDR_CFG, t[3:0] & 4'hE);
    wr(`ADDR_CFG, 4'h0);
    wr(`ADDR_CTL, 4'h1);
    rd(`ADDR_CTL, 4'h0);
    // CPU run over 125 steps: window is exactly 1250 cycles
    irq_n = 0;
    wr(`ADDR_CTL, 4'h8);
    repeat (1248) @(posedge core_clk_in);
    wr(`ADDR_CTL, 4'h0);
    rd(`ADDR_THOUSANDTHS, 4'h5);
    rd(`ADDR_HUNDREDTHS, 4'h2);
    rd(`ADDR_TENTHS, 4'h1);
    check("irq_tenths", irq_n, 1);
    wr(`ADDR_CTL, 4'h1);
    rd(`ADDR_THOUSANDTHS, 4'h0);
    // Full wrap with the once-a-second request
    irq_n = 0;
    wr(`ADDR_CFG, 4'h2);
    wr(`ADDR_CTL, 4'h8);
    repeat (9998) @(posedge core_clk_in);
    wr(`ADDR_CTL, 4'h0);
    for (int a = 2; a < 5; a++) rd(a, 4'h0);
    rd(`ADDR_CFG, 4'h3);
    rd(`ADDR_CFG, 4'h2);
    check("irq_second", irq_n, 1);
    // Pulse width on both debounce taps
    for (int d = 0; d < 2; d++) begin
      wr(`ADDR_CFG, {d[0], 3'b100});
      wr(`ADDR_CTL, 4'hE);
      repeat (40) @(posedge core_clk_in);
      check("armed_idle", counting, 1'b0);
      pin_level <= 1'b1;
      wait_cnt(1'b1, d ? 20 : 0, d ? 200 : 30);
      repeat (30 + $urandom % 30) @(posedge core_clk_in);
      pin_level <= 1'b0;
      wait_cnt(1'b0, 0, 200);
      rd(`ADDR_CTL, 4'h6);
    end
    // Start/stop with inverted pin, edges alternate
    pin_level <= 1'b1;
    repeat (80) @(posedge core_clk_in);
    wr(`ADDR_CFG, 4'h0);
    wr(`ADDR_CTL, 4'hC);
    repeat (20) @(posedge core_clk_in);
    check("armed_idle", counting, 1'b0);
    pin_level <= 1'b0;
    wait_cnt(1'b1, 0, 30);
    pin_level <= 1'b1;
    repeat (40) @(posedge core_clk_in);
    check("still_running", counting, 1'b1);
    pin_level <= 1'b0;
    wait_cnt(1'b0, 0, 30);
    rd(`ADDR_CTL, 4'hC);
    // CPU start, stop by an edge made from the edge select
    pin_level <= 1'b1;
    repeat (80) @(posedge core_clk_in);
    wr(`ADDR_CTL, 4'hA);
    wait_cnt(1'b1, 0, 3);
    wr(`ADDR_CFG, 4'h4);
    wr(`ADDR_CFG, 4'h0);
    repeat (5) @(posedge core_clk_in);
    check("cpu_ignores_edge", counting, 1'b1);
    wr(`ADDR_CTL, 4'hE);
    wr(`ADDR_CFG, 4'h4);
    wait_cnt(1'b0, 0, 5);
    rd(`ADDR_CTL, 4'h6);
    // Reset in mid-run stops the count and clears every register
    wr(`ADDR_CTL, 4'h8);
    repeat (40) @(posedge core_clk_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    #1;
    check("reset_stops", counting, 1'b0);
    for (int a = 0; a < 5; a++) rd(a, 4'h0);
    repeat (3) @(posedge core_clk_in);
    test_done();
  end
endmodule
`default_nettype wire
